// ---- include/epw_pkg.sv ----
package epw_pkg;
  // ------------------------------------------------------------
  // direct host addresses
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_SELECT = 8'h6E;
  localparam logic [7:0] ADDR_OFFSET = 8'h6F;
  localparam logic [7:0] ADDR_DATA = 8'hA0;

  // ------------------------------------------------------------
  // select register fields
  // ------------------------------------------------------------
  localparam int SEL_FUNC_MSB = 7;
  localparam int SEL_FUNC_LSB = 5;
  localparam int SEL_PORT_MSB = 3;
  localparam int SEL_PORT_LSB = 0;
  localparam logic [2:0] FUNC_EEE = 3'h1;
  localparam logic [3:0] PORT_FIRST = 4'h1;
  localparam logic [3:0] PORT_LAST = 4'h3;
  localparam int NUM_PORTS = 3;

  // ------------------------------------------------------------
  // indirect offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CAP_HI = 8'h28;
  localparam logic [7:0] OFS_CAP_LO = 8'h29;
  localparam logic [7:0] OFS_WAKE_HI = 8'h2A;
  localparam logic [7:0] OFS_WAKE_LO = 8'h2B;

  // ------------------------------------------------------------
  // capability register fields, reset and idle values
  // ------------------------------------------------------------
  localparam int CAP_LP_LSB = 9;
  localparam int CAP_LP_WIDTH = 6;
  localparam int CAP_LOCAL_TX100_BIT = 1;
  localparam logic LOCAL_TX100_RESET = 1'b1;
  localparam logic [15:0] WAKE_COUNT_RESET = 16'h0000;
  localparam logic [15:0] WAKE_COUNT_MAX = 16'hFFFF;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [7:0] OFFSET_RESET = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 20000;
  localparam int WAKE_THRESH_PS = 20500000;
  localparam int WAKE_THRESH_CYC_INT = WAKE_THRESH_PS / CLK_PERIOD_PS;
  localparam logic [15:0] WAKE_THRESH_CYC = WAKE_THRESH_CYC_INT[15:0];
endpackage

// ---- logic/epw_wake_counter.sv ----
`timescale 1ns/1ps
module epw_wake_counter (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // threshold and wake events
  input wire logic [15:0] thresh_cyc_i,
  input wire logic wake_start_i,
  input wire logic wake_done_i,
  // host side
  input wire logic clear_i,
  output logic [15:0] count_o
);
  logic waking;
  logic [15:0] timer;
  logic hit;

  // ------------------------------------------------------------
  // wake duration timer
  // ------------------------------------------------------------
  // one hit per wake: only the cycle the timer lands on the threshold;
  // the hit also ends the wake, so a timer parked at max cannot count twice
  assign hit = waking && !wake_done_i && (timer == thresh_cyc_i);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      waking <= 1'b0;
    end else if (ce_i) begin
      if (wake_start_i) begin
        waking <= 1'b1;
      end else if (wake_done_i || hit) begin
        waking <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer <= 16'h0000;
    end else if (ce_i) begin
      if (wake_start_i) begin
        timer <= 16'h0001;
      end else if (waking && timer != 16'hFFFF) begin
        timer <= timer + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // error counter
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= epw_pkg::WAKE_COUNT_RESET;
    end else if (ce_i) begin
      // (RULE6) read clear, event wins
      if (clear_i) begin
        count_o <= hit ? 16'h0001 : epw_pkg::WAKE_COUNT_RESET;
      // (RULE4) count slow wakes
      end else if (hit && count_o != epw_pkg::WAKE_COUNT_MAX) begin
        // (RULE12) saturate at max
        count_o <= count_o + 16'h0001;
      end
    end
  end
endmodule

// ---- logic/epw_port_regs.sv ----
`timescale 1ns/1ps
// Functional notes
// (RULE1) bits 13-11 show partner backplane/10GT EEE
// (RULE2) bits 10-9 show partner 1000T/100TX EEE
// (RULE3) bit 1 local 100TX advert, resets one
// (RULE4) count each wake slower than threshold
// (RULE5) threshold from global register, default 20.5us
// (RULE6) counter resets zero, cleared on read
// (RULE7) function 001 at 0x6E, data 0xA0
// (RULE8) port 1-3 in select, offset 0x6F
// (RULE9) counter high 0x2A, low 0x2B
// (RULE10) capability high 0x28, low 0x29
// (RULE11) bit 14 shows partner 10G KR EEE
// (RULE12) counter saturates instead of wrapping
module epw_port_regs #(
  parameter int NUM_PORTS = epw_pkg::NUM_PORTS,
  parameter logic [15:0] WAKE_THRESH_CYC = epw_pkg::WAKE_THRESH_CYC
) (
  // clock, reset, enable
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // host byte register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // global threshold register
  input wire logic thresh_wr_i,
  input wire logic [15:0] thresh_cyc_i,
  // per-port phy side
  input wire logic [NUM_PORTS*6-1:0] link_partner_cap_i,
  input wire logic [NUM_PORTS-1:0] wake_start_i,
  input wire logic [NUM_PORTS-1:0] wake_done_i,
  output logic [NUM_PORTS-1:0] local_tx100_adv_o
);
  logic [7:0] select_reg;
  logic [7:0] offset_reg;
  logic [15:0] thresh;
  logic [2:0] sel_func;
  logic [3:0] sel_port;
  logic [3:0] port_idx;
  logic eee_hit;
  logic data_wr;
  logic data_rd;
  logic [15:0] count [NUM_PORTS];
  logic [15:0] snap [NUM_PORTS];
  logic [NUM_PORTS-1:0] snap_pend;
  logic [NUM_PORTS-1:0] clear;
  logic [7:0] next_rdata;

  // ------------------------------------------------------------
  // indirect select decode
  // ------------------------------------------------------------
  assign sel_func = select_reg[epw_pkg::SEL_FUNC_MSB:epw_pkg::SEL_FUNC_LSB];
  assign sel_port = select_reg[epw_pkg::SEL_PORT_MSB:epw_pkg::SEL_PORT_LSB];
  assign port_idx = sel_port - epw_pkg::PORT_FIRST;
  // (RULE7) eee function gate
  // (RULE8) legal port range only
  assign eee_hit = (sel_func == epw_pkg::FUNC_EEE)
                   && (sel_port >= epw_pkg::PORT_FIRST)
                   && (sel_port <= epw_pkg::PORT_LAST)
                   && (port_idx < 4'(NUM_PORTS));
  assign data_wr = reg_wr_i && (reg_addr_i == epw_pkg::ADDR_DATA) && eee_hit;
  assign data_rd = reg_rd_i && (reg_addr_i == epw_pkg::ADDR_DATA) && eee_hit;

  // ------------------------------------------------------------
  // direct registers
  // ------------------------------------------------------------
  // (RULE7) select register store
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      select_reg <= epw_pkg::SELECT_RESET;
    end else if (ce_i && reg_wr_i && reg_addr_i == epw_pkg::ADDR_SELECT) begin
      select_reg <= reg_wdata_i;
    end
  end

  // (RULE8) offset register store
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      offset_reg <= epw_pkg::OFFSET_RESET;
    end else if (ce_i && reg_wr_i && reg_addr_i == epw_pkg::ADDR_OFFSET) begin
      offset_reg <= reg_wdata_i;
    end
  end

  // (RULE5) threshold default and load
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      thresh <= WAKE_THRESH_CYC;
    end else if (ce_i && thresh_wr_i) begin
      thresh <= thresh_cyc_i;
    end
  end

  // ------------------------------------------------------------
  // per-port slices
  // ------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic sel_me;
    assign sel_me = (port_idx == 4'(p));
    // (RULE6) clear on high byte read, or on low byte read with no snapshot pending
    // reading the low byte right after the high one returns the snapshot,
    // so a 16-bit read in high-then-low order is coherent
    assign clear[p] = data_rd && sel_me
                      && ((offset_reg == epw_pkg::OFS_WAKE_HI)
                          || (offset_reg == epw_pkg::OFS_WAKE_LO && !snap_pend[p]));

    // (RULE3) local advert write
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        local_tx100_adv_o[p] <= epw_pkg::LOCAL_TX100_RESET;
      end else if (ce_i && data_wr && sel_me && offset_reg == epw_pkg::OFS_CAP_LO) begin
        local_tx100_adv_o[p] <= reg_wdata_i[epw_pkg::CAP_LOCAL_TX100_BIT];
      end
    end

    // (RULE9) high read snapshots count
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        snap[p] <= epw_pkg::WAKE_COUNT_RESET;
        snap_pend[p] <= 1'b0;
      end else if (ce_i && data_rd && sel_me) begin
        if (offset_reg == epw_pkg::OFS_WAKE_HI) begin
          snap[p] <= count[p];
          snap_pend[p] <= 1'b1;
        end else if (offset_reg == epw_pkg::OFS_WAKE_LO) begin
          snap_pend[p] <= 1'b0;
        end
      end
    end

    epw_wake_counter u_wake (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .thresh_cyc_i(thresh),
      .wake_start_i(wake_start_i[p]),
      .wake_done_i(wake_done_i[p]),
      .clear_i(clear[p]),
      .count_o(count[p])
    );
  end

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  always_comb begin
    logic [15:0] cap;
    logic [15:0] cnt;
    logic pend;
    cap = 16'h0000;
    cnt = 16'h0000;
    pend = 1'b0;
    next_rdata = epw_pkg::RDATA_IDLE;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (port_idx == 4'(i)) begin
        // (RULE1) partner caps 13-11
        // (RULE2) partner caps 10-9
        // (RULE11) partner cap bit 14
        cap[epw_pkg::CAP_LP_LSB +: epw_pkg::CAP_LP_WIDTH] =
          link_partner_cap_i[i*6 +: 6];
        // (RULE3) local advert readback
        cap[epw_pkg::CAP_LOCAL_TX100_BIT] = local_tx100_adv_o[i];
        cnt = snap_pend[i] ? snap[i] : count[i];
        pend = snap_pend[i];
      end
    end
    if (reg_addr_i == epw_pkg::ADDR_SELECT) begin
      next_rdata = select_reg;
    end else if (reg_addr_i == epw_pkg::ADDR_OFFSET) begin
      next_rdata = offset_reg;
    end else if (reg_addr_i == epw_pkg::ADDR_DATA && eee_hit) begin
      unique case (offset_reg)
        // (RULE10) capability byte map
        epw_pkg::OFS_CAP_HI: next_rdata = cap[15:8];
        epw_pkg::OFS_CAP_LO: next_rdata = cap[7:0];
        // (RULE9) counter byte map
        epw_pkg::OFS_WAKE_HI: next_rdata = count[port_idx[1:0]][15:8];
        epw_pkg::OFS_WAKE_LO: next_rdata = pend ? cnt[7:0] : count[port_idx[1:0]][7:0];
        default: next_rdata = epw_pkg::RDATA_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // read data register
  // ------------------------------------------------------------
  // registered so the host sees a stable byte one cycle after the strobe
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= epw_pkg::RDATA_IDLE;
      reg_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= next_rdata;
      end
    end
  end
endmodule

// ---- sim/epw_port_regs_props.sv ----
`timescale 1ns/1ps
// ------
// port checks
// ------
module epw_port_regs_props #(parameter int NUM_PORTS = 3) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // host byte port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  // phy side
  input wire logic [NUM_PORTS*6-1:0] link_partner_cap_i,
  input wire logic [NUM_PORTS-1:0] local_tx100_adv_o
);
  logic [7:0] sel;
  logic [7:0] ofs;
  logic ok, rd, wr, adv, advw;
  logic [5:0] cap;
  // shadow of select and offset, tracked from the port only
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel <= 8'h00;
      ofs <= 8'h00;
    end else if (ce_i && reg_wr_i) begin
      if (reg_addr_i == epw_pkg::ADDR_SELECT) sel <= reg_wdata_i;
      if (reg_addr_i == epw_pkg::ADDR_OFFSET) ofs <= reg_wdata_i;
    end
  end
  always_comb begin
    ok = sel[7:5] == epw_pkg::FUNC_EEE && sel[3:0] != 4'h0 && sel[3:0] <= 4'(NUM_PORTS);
    rd = ce_i && reg_rd_i && reg_addr_i == epw_pkg::ADDR_DATA;
    wr = ce_i && reg_wr_i && reg_addr_i == epw_pkg::ADDR_DATA;
    cap = 6'(link_partner_cap_i >> (6 * (sel[3:0] - 4'h1)));
    adv = local_tx100_adv_o[sel[1:0] - 2'h1];
    advw = wr && ok && ofs == epw_pkg::OFS_CAP_LO;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_rvalid; ce_i && reg_rd_i |=> reg_rvalid_o; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_lone; reg_rvalid_o |-> $past(rd) || $past(ce_i && reg_rd_i); endproperty
  a_lone: assert property (p_lone) else $error("answer without read");
  property p_hold; $changed(reg_rdata_o) |-> reg_rvalid_o; endproperty
  a_hold: assert property (p_hold) else $error("read byte moved");
  property p_refuse; rd && !ok |=> reg_rdata_o == epw_pkg::RDATA_IDLE; endproperty
  a_refuse: assert property (p_refuse) else $error("bad select read");
  property p_cap_hi; rd && ok && ofs == epw_pkg::OFS_CAP_HI |=> reg_rdata_o == {1'b0, $past(cap), 1'b0}; endproperty
  a_cap_hi: assert property (p_cap_hi) else $error("cap high byte");
  property p_cap_lo; rd && ok && ofs == epw_pkg::OFS_CAP_LO |=> reg_rdata_o == {6'h00, $past(adv), 1'b0}; endproperty
  a_cap_lo: assert property (p_cap_lo) else $error("cap low byte");
  property p_adv_wr; advw |=> adv == $past(reg_wdata_i[1]); endproperty
  a_adv_wr: assert property (p_adv_wr) else $error("advert not written");
  property p_adv_src; $changed(local_tx100_adv_o) |-> $past(advw); endproperty
  a_adv_src: assert property (p_adv_src) else $error("advert moved alone");
  property p_unmap; rd && ok && (ofs < 8'h28 || ofs > 8'h2B) |=> reg_rdata_o == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped offset");
  c_wake: cover property (rd && ok && ofs == epw_pkg::OFS_WAKE_HI);
  c_adv: cover property (advw);
  c_bad: cover property (rd && !ok);
endmodule

// ---- sim/epw_host_model.sv ----
`timescale 1ns/1ps
// ------
// host side of the indirect byte access
// ------
module epw_host_model (
  // clock
  input wire logic clk_i,
  // byte port
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i
);
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    // released bus shows the inverse, not the last byte
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    for (n = 0; n < 4 && rvalid_i !== 1'b1; n++) @(negedge clk_i);
    d = rdata_i;
  endtask
  task automatic pick(input logic [2:0] f, input logic [3:0] p, input logic [7:0] o);
    wr(epw_pkg::ADDR_SELECT, {f, 1'b0, p});
    wr(epw_pkg::ADDR_OFFSET, o);
  endtask
endmodule

// ---- sim/epw_port_regs_test.sv ----
`timescale 1ns/1ps
module epw_port_regs_test;
  localparam int THR = 20500 / 20;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr, wdata, rdata, v;
  logic wr, rd, rvalid;
  logic twr = 1'b0;
  logic ce = 1'b1;
  logic [15:0] tcyc = 16'h0008;
  logic [17:0] cap = 18'h0_0000;
  logic [2:0] ws = 3'h0, wd = 3'h0, adv, advx = 3'h7;
  logic [7:0] bsel [5] = '{8'h41, 8'h20, 8'h24, 8'h21, 8'h21};
  logic [7:0] bofs [5] = '{8'h29, 8'h29, 8'h29, 8'h2C, 8'h27};
  int err_total = 0, total_checks = 0, cyc = 0, i;
  always #10 core_clk_i = ~core_clk_i;
  epw_port_regs dut_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .thresh_wr_i(twr), .thresh_cyc_i(tcyc),
    .link_partner_cap_i(cap), .wake_start_i(ws), .wake_done_i(wd), .local_tx100_adv_o(adv));
  epw_host_model host_u (.clk_i(core_clk_i), .addr_o(addr), .wr_o(wr), .rd_o(rd),
    .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task get(input logic [3:0] p, input logic [7:0] o, output logic [7:0] d);
    host_u.pick(epw_pkg::FUNC_EEE, p, o);
    host_u.rd(epw_pkg::ADDR_DATA, d);
  endtask
  task wake(input int p, input int n);
    @(negedge core_clk_i);
    ws[p] = 1'b1;
    @(negedge core_clk_i);
    ws[p] = 1'b0;
    repeat (n) @(negedge core_clk_i);
    wd[p] = 1'b1;
    @(negedge core_clk_i);
    wd[p] = 1'b0;
  endtask
  task scan(input string nm);
    int p;
    for (p = 1; p <= 3; p++) begin
      get(p[3:0], epw_pkg::OFS_CAP_HI, v);
      chk(v, {1'b0, cap[(p-1)*6 +: 6], 1'b0});
      get(p[3:0], epw_pkg::OFS_CAP_LO, v);
      chk(v, {6'h00, advx[p-1], 1'b0});
      get(p[3:0], epw_pkg::OFS_WAKE_HI, v);
      chk(v, 16'h0000);
      get(p[3:0], epw_pkg::OFS_WAKE_LO, v);
      chk(v, 16'h0000);
    end
    chk(adv, advx);
    $display("test %s done", nm);
  endtask
  // hang guard, the saturation run alone needs about 66000 cycles
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 80000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    repeat (6) @(negedge core_clk_i);
    rst_i = 1'b0;
    scan("reset");
    cap = {6'h2A, 6'h15, 6'h3F};
    host_u.pick(epw_pkg::FUNC_EEE, 4'h2, epw_pkg::OFS_CAP_LO);
    host_u.wr(epw_pkg::ADDR_DATA, 8'hFD);
    host_u.pick(epw_pkg::FUNC_EEE, 4'h1, epw_pkg::OFS_CAP_HI);
    host_u.wr(epw_pkg::ADDR_DATA, 8'h00);
    advx = 3'b101;
    scan("caps");
    for (i = 0; i < 5; i++) begin
      host_u.wr(epw_pkg::ADDR_SELECT, bsel[i]);
      host_u.wr(epw_pkg::ADDR_OFFSET, bofs[i]);
      host_u.rd(epw_pkg::ADDR_DATA, v);
      chk(v, 16'h0000);
      host_u.wr(epw_pkg::ADDR_DATA, 8'h00);
      chk(adv, advx);
    end
    $display("test refused done");
    host_u.pick(epw_pkg::FUNC_EEE, 4'h1, epw_pkg::OFS_CAP_LO);
    @(negedge core_clk_i);
    ce = 1'b0;
    host_u.wr(epw_pkg::ADDR_DATA, 8'h00);
    ce = 1'b1;
    chk(adv, advx);
    host_u.rd(epw_pkg::ADDR_SELECT, v);
    chk(v, 16'h0021);
    host_u.rd(epw_pkg::ADDR_OFFSET, v);
    chk(v, epw_pkg::OFS_CAP_LO);
    $display("test freeze done");
    wake(0, THR + 15);
    wake(0, THR - 15);
    wake(0, THR + 15);
    wake(2, THR - 15);
    get(4'h1, epw_pkg::OFS_WAKE_HI, v);
    chk(v, 16'h0000);
    get(4'h1, epw_pkg::OFS_WAKE_LO, v);
    chk(v, 16'h0002);
    get(4'h1, epw_pkg::OFS_WAKE_LO, v);
    chk(v, 16'h0000);
    get(4'h3, epw_pkg::OFS_WAKE_LO, v);
    chk(v, 16'h0000);
    @(negedge core_clk_i);
    twr = 1'b1;
    @(negedge core_clk_i);
    twr = 1'b0;
    wake(1, 12);
    wake(1, 4);
    get(4'h2, epw_pkg::OFS_WAKE_LO, v);
    chk(v, 16'h0001);
    @(negedge core_clk_i);
    tcyc = 16'h0001;
    twr = 1'b1;
    @(negedge core_clk_i);
    twr = 1'b0;
    ws[2] = 1'b1;
    repeat (65540) @(negedge core_clk_i);
    ws[2] = 1'b0;
    get(4'h3, epw_pkg::OFS_WAKE_HI, v);
    chk(v, 16'h00FF);
    get(4'h3, epw_pkg::OFS_WAKE_LO, v);
    chk(v, 16'h00FF);
    get(4'h3, epw_pkg::OFS_WAKE_LO, v);
    chk(v, 16'h0000);
    $display("test wake done");
    summarize();
  end
endmodule
bind epw_port_regs epw_port_regs_props #(.NUM_PORTS(NUM_PORTS)) chk_u (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
  .link_partner_cap_i(link_partner_cap_i), .local_tx100_adv_o(local_tx100_adv_o));
